// ==== bbl_consts.svh ====
// timing, count and encoding constants for the blanking and burst level block
`ifndef BBL_CONSTS_SVH
`define BBL_CONSTS_SVH

`define BBL_CLK_HZ          100000000
`define BBL_BLANK_MS        20
`define BBL_SPIKE_MS        30
`define BBL_DETECT_MS       1
`define BBL_BLANK_CYC       ((`BBL_BLANK_MS * (`BBL_CLK_HZ / 1000)))
`define BBL_SPIKE_CYC       ((`BBL_SPIKE_MS * (`BBL_CLK_HZ / 1000)))
`define BBL_DETECT_CYC      ((`BBL_DETECT_MS * (`BBL_CLK_HZ / 1000)))
`define BBL_EXT_COUNT       256
`define BBL_LVL_B1          16'h0004
`define BBL_LVL_B2          16'h0010
`define BBL_LVL_B3          16'h0040
`define BBL_ADDR_CTRL       4'h0
`define BBL_ADDR_STAT       4'h4
`define BBL_ADDR_LVL        4'h8
`define BBL_ADDR_CNT        4'hc
`define BBL_CTRL_RST        32'h0000_0001

`endif

// ==== bbl_pkg.sv ====
// types for the blanking and burst level block
package bbl_pkg;
  typedef enum logic [1:0] {
    BBL_LVL_HIGH  = 2'b00,
    BBL_LVL_MID   = 2'b01,
    BBL_LVL_LOW   = 2'b10,
    BBL_LVL_NEVER = 2'b11
  } bbl_level_t;

  typedef enum logic [2:0] {
    BBL_OV_IDLE   = 3'b000,
    BBL_OV_BLANK  = 3'b001,
    BBL_OV_CHARGE = 3'b010,
    BBL_OV_DISCH  = 3'b011,
    BBL_OV_SPIKE  = 3'b100,
    BBL_OV_FAULT  = 3'b101
  } bbl_ov_t;

  typedef enum logic [1:0] {
    BBL_DT_WAIT   = 2'b00,
    BBL_DT_CHARGE = 2'b01,
    BBL_DT_DISCH  = 2'b10,
    BBL_DT_DONE   = 2'b11
  } bbl_dt_t;
endpackage

// ==== bbl_sync.sv ====
// two flip-flop synchroniser for a bundle of pin-level inputs
`timescale 1ns/100ps
module bbl_sync #(
  parameter int W = 1
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } bbl_sync_st_t;

  bbl_sync_st_t st_q;
  bbl_sync_st_t st_d;

  always_comb begin
    st_d    = st_q;
    st_d.s1 = din;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign dout = st_q.s2;
endmodule

// ==== bbl_top.sv ====
// blanking timers, extendable overload blanking and burst level selection
//
// Register access over AXI4-Lite and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
`include "bbl_consts.svh"

// What this block does
// - 20 ms blanking before burst mode or restart protection mode
// - extendable mode: after 20 ms keep blocked, start counter, close charge switch
// - upper comparator hit: count up, open charge, close discharge switch
// - lower comparator hit: open discharge, close charge switch again
// - cycle until count 256, then raise completion output
// - both high: 30 ms spike blanking, then restart protection mode
// - slope-dependent current trip threshold, handled in the analog front end
// - same slope compensation on reduced burst current limit, analog
// - four entry thresholds 1.60, 1.42, 1.27 V or never, by capacitor
// - paired burst current limit 0.45, 0.37, 0.31 V or always exit
// - detect only in first 1 ms after first supply release, never again
// - postpone detection while a protection condition is active
// - feedback at 0.5 V: reset detect flipflop, release discharge switch
// - at window end stop cycling and latch level from count
// - burst hysteresis swing select 0.3 V instead of 0.5 V
// - burst timer held at zero, runs below threshold, enter after 20 ms
// - leave burst mode when feedback rises above 4.0 V
module bbl_top #(
  parameter int BLANK_CYC  = `BBL_BLANK_CYC,
  parameter int SPIKE_CYC  = `BBL_SPIKE_CYC,
  parameter int DETECT_CYC = `BBL_DETECT_CYC,
  parameter int CNT_W      = 16
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        overload_cmp,
  input  wire logic        blank_hi_cmp,
  input  wire logic        blank_lo_cmp,
  input  wire logic        fb_below_entry_cmp,
  input  wire logic        fb_above_exit_cmp,
  input  wire logic        fb_hi_cmp,
  input  wire logic        fb_lo_cmp,
  input  wire logic        uvlo_on,
  input  wire logic        protect_active,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             charge_switch,
  output logic             discharge_switch,
  output logic             detect_discharge_switch,
  output logic             ext_count_done,
  output logic             restart_protect,
  output logic             burst_mode,
  output logic             burst_hyst_small,
  output logic [1:0]       burst_entry_threshold,
  output logic [1:0]       burst_current_limit
);
  // ----------------------------------------------------------------
  // synchronised analog comparator, supply and protection pin levels
  // ----------------------------------------------------------------
  logic [8:0] pins_s;
  bbl_sync #(.W(9)) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .din     ({overload_cmp, blank_hi_cmp, blank_lo_cmp, fb_below_entry_cmp,
                fb_above_exit_cmp, fb_hi_cmp, fb_lo_cmp, uvlo_on, protect_active}),
    .dout    (pins_s)
  );
  logic ovl, bhi, blo, fbl, fbx, fhi, flo, uvo, prt;
  assign {ovl, bhi, blo, fbl, fbx, fhi, flo, uvo, prt} = pins_s;
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    bbl_pkg::bbl_ov_t    ov;
    logic [31:0]         ov_tmr;
    logic [8:0]          ext_cnt;
    logic                ext_en;
    logic                ext_done;
    logic                chg;
    logic                dis;
    logic                rst_prot;
    logic [31:0]         bu_tmr;
    logic                burst;
    bbl_pkg::bbl_dt_t    dt;
    logic [31:0]         dt_tmr;
    logic [CNT_W-1:0]    dt_cnt;
    logic                det_ff;
    logic                det_done;
    bbl_pkg::bbl_level_t lvl;
    logic                aw_got;
    logic                w_got;
    logic [31:0]         aw_a;
    logic [31:0]         w_d;
    logic                bvalid;
    logic                rvalid;
    logic [31:0]         rdata;
    logic [1:0]          rresp;
    logic [1:0]          bresp;
    logic [2:0]          rdy;
  } bbl_st_t;
  bbl_st_t st_q;
  bbl_st_t st_d;
  always_comb begin
    st_d = st_q;
    // ----------------------------------------------------------------
    // overload blanking
    // ----------------------------------------------------------------
    if (!ovl && st_q.ov != bbl_pkg::BBL_OV_FAULT) begin
      st_d.ov       = bbl_pkg::BBL_OV_IDLE;
      st_d.ov_tmr   = '0;
      st_d.ext_cnt  = '0;
      st_d.ext_done = 1'b0;
      st_d.chg      = 1'b0;
      st_d.dis      = 1'b0;
    end else begin
      case (st_q.ov)
        bbl_pkg::BBL_OV_IDLE: begin
          st_d.ov     = bbl_pkg::BBL_OV_BLANK;
          st_d.ov_tmr = 32'h0000_0001;
        end
        bbl_pkg::BBL_OV_BLANK: begin
          if (st_q.ov_tmr >= 32'(BLANK_CYC)) begin
            if (st_q.ext_en) begin
              st_d.ov  = bbl_pkg::BBL_OV_CHARGE;
              st_d.chg = 1'b1;
            end else begin
              st_d.ov       = bbl_pkg::BBL_OV_SPIKE;
              st_d.ext_done = 1'b1;
              st_d.ov_tmr   = '0;
            end
          end else begin
            st_d.ov_tmr = st_q.ov_tmr + 32'h0000_0001;
          end
        end
        bbl_pkg::BBL_OV_CHARGE: begin
          if (bhi) begin
            st_d.ext_cnt = st_q.ext_cnt + 9'h001;
            st_d.chg     = 1'b0;
            st_d.dis     = 1'b1;
            st_d.ov      = bbl_pkg::BBL_OV_DISCH;
          end
        end
        bbl_pkg::BBL_OV_DISCH: begin
          if (st_q.ext_cnt >= 9'(`BBL_EXT_COUNT)) begin
            st_d.dis      = 1'b0;
            st_d.ext_done = 1'b1;
            st_d.ov       = bbl_pkg::BBL_OV_SPIKE;
            st_d.ov_tmr   = '0;
          end else if (blo) begin
            st_d.dis = 1'b0;
            st_d.chg = 1'b1;
            st_d.ov  = bbl_pkg::BBL_OV_CHARGE;
          end
        end
        bbl_pkg::BBL_OV_SPIKE: begin
          if (st_q.ov_tmr >= 32'(SPIKE_CYC) - 32'h0000_0001) begin
            st_d.ov       = bbl_pkg::BBL_OV_FAULT;
            st_d.rst_prot = 1'b1;
          end else begin
            st_d.ov_tmr = st_q.ov_tmr + 32'h0000_0001;
          end
        end
        default: begin
          st_d.rst_prot = 1'b1;
        end
      endcase
    end
    // ----------------------------------------------------------------
    // burst entry and exit
    // ----------------------------------------------------------------
    if (st_q.burst) begin
      st_d.burst  = !fbx;
      st_d.bu_tmr = '0;
    end else if (!fbl || st_q.lvl == bbl_pkg::BBL_LVL_NEVER || !st_q.det_done) begin
      st_d.bu_tmr = '0;
    end else if (st_q.bu_tmr >= 32'(BLANK_CYC) - 32'h0000_0001) begin
      st_d.burst  = 1'b1;
      st_d.bu_tmr = '0;
    end else begin
      st_d.bu_tmr = st_q.bu_tmr + 32'h0000_0001;
    end
    // ----------------------------------------------------------------
    // one-time level detection
    // ----------------------------------------------------------------
    case (st_q.dt)
      bbl_pkg::BBL_DT_WAIT: begin
        if (uvo && !prt) begin
          st_d.dt = bbl_pkg::BBL_DT_CHARGE;
        end
      end
      bbl_pkg::BBL_DT_CHARGE, bbl_pkg::BBL_DT_DISCH: begin
        st_d.dt_tmr = st_q.dt_tmr + 32'h0000_0001;
        if (st_q.dt_tmr >= 32'(DETECT_CYC) - 32'h0000_0001) begin
          st_d.dt       = bbl_pkg::BBL_DT_DONE;
          st_d.det_ff   = 1'b0;
          st_d.det_done = 1'b1;
          if (st_q.dt_cnt >= CNT_W'(`BBL_LVL_B3)) begin
            st_d.lvl = bbl_pkg::BBL_LVL_NEVER;
          end else if (st_q.dt_cnt >= CNT_W'(`BBL_LVL_B2)) begin
            st_d.lvl = bbl_pkg::BBL_LVL_LOW;
          end else if (st_q.dt_cnt >= CNT_W'(`BBL_LVL_B1)) begin
            st_d.lvl = bbl_pkg::BBL_LVL_MID;
          end else begin
            st_d.lvl = bbl_pkg::BBL_LVL_HIGH;
          end
        end else if (st_q.dt == bbl_pkg::BBL_DT_CHARGE && fhi) begin
          st_d.det_ff = 1'b1;
          st_d.dt_cnt = st_q.dt_cnt + CNT_W'(1);
          st_d.dt     = bbl_pkg::BBL_DT_DISCH;
        end else if (st_q.dt == bbl_pkg::BBL_DT_DISCH && flo) begin
          st_d.det_ff = 1'b0;
          st_d.dt     = bbl_pkg::BBL_DT_CHARGE;
        end
      end
      default: begin
        st_d.dt = bbl_pkg::BBL_DT_DONE;
      end
    endcase
    // ----------------------------------------------------------------
    // axi4-lite slave
    // ----------------------------------------------------------------
    if (s_axi_awvalid && st_q.rdy[2]) begin
      st_d.aw_got = 1'b1;
      st_d.aw_a   = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_q.rdy[1]) begin
      st_d.w_got = 1'b1;
      st_d.w_d   = s_axi_wdata;
    end
    if (st_q.aw_got && st_q.w_got && !st_q.bvalid) begin
      st_d.aw_got = 1'b0;
      st_d.w_got  = 1'b0;
      st_d.bvalid = 1'b1;
      st_d.bresp  = 2'b10;
      if (st_q.aw_a == 32'(`BBL_ADDR_CTRL)) begin
        st_d.bresp  = 2'b00;
        st_d.ext_en = st_q.w_d[0];
      end
    end
    if (st_q.bvalid && s_axi_bready) begin
      st_d.bvalid = 1'b0;
    end
    if (s_axi_arvalid && st_q.rdy[0]) begin
      st_d.rvalid = 1'b1;
      st_d.rresp  = 2'b00;
      if (s_axi_araddr == 32'(`BBL_ADDR_CTRL)) begin
        st_d.rdata = {31'h0, st_q.ext_en};
      end else if (s_axi_araddr == 32'(`BBL_ADDR_STAT)) begin
        st_d.rdata = {25'h0, st_q.det_done, st_q.det_ff, st_q.burst, st_q.rst_prot,
                      st_q.ext_done, st_q.dis, st_q.chg};
      end else if (s_axi_araddr == 32'(`BBL_ADDR_LVL)) begin
        st_d.rdata = {30'h0, st_q.lvl};
      end else if (s_axi_araddr == 32'(`BBL_ADDR_CNT)) begin
        st_d.rdata = {7'h0, st_q.ext_cnt, (CNT_W)'(st_q.dt_cnt)};
      end else begin
        st_d.rdata = 32'h0;
        st_d.rresp = 2'b10;
      end
    end
    if (st_q.rvalid && s_axi_rready) begin
      st_d.rvalid = 1'b0;
    end
    st_d.rdy = {!st_d.aw_got && !st_d.bvalid, !st_d.w_got && !st_d.bvalid, !st_d.rvalid};
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
  // ----------------------------------------------------------------
  // outputs, all registered
  // ----------------------------------------------------------------
  assign s_axi_awready           = st_q.rdy[2];
  assign s_axi_wready            = st_q.rdy[1];
  assign s_axi_bvalid            = st_q.bvalid;
  assign s_axi_bresp             = st_q.bresp;
  assign s_axi_arready           = st_q.rdy[0];
  assign s_axi_rvalid            = st_q.rvalid;
  assign s_axi_rdata             = st_q.rdata;
  assign s_axi_rresp             = st_q.rresp;
  assign charge_switch           = st_q.chg;
  assign discharge_switch        = st_q.dis;
  assign detect_discharge_switch = st_q.det_ff;
  assign ext_count_done          = st_q.ext_done;
  assign restart_protect         = st_q.rst_prot;
  assign burst_mode              = st_q.burst;
  assign burst_hyst_small        = st_q.burst;
  assign burst_entry_threshold   = st_q.lvl;
  assign burst_current_limit     = st_q.lvl;
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_chg_dis_excl: assert property (@(posedge aclk) disable iff (!aresetn)
    !(st_q.chg && st_q.dis)) else $error("charge and discharge both closed");
  a_cnt_step: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_q.ov == bbl_pkg::BBL_OV_CHARGE && bhi && ovl) |=> st_q.dis && !st_q.chg)
    else $error("upper hit did not swap switches");
  a_dis_release: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_q.ov == bbl_pkg::BBL_OV_DISCH && blo && ovl && st_q.ext_cnt < 9'h100)
    |=> st_q.chg && !st_q.dis) else $error("lower hit did not recharge");
  a_ovl_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    (!ovl && st_q.ov != bbl_pkg::BBL_OV_FAULT) |=> st_q.ext_cnt == 9'h0 && !st_q.chg)
    else $error("overload removal did not clear");
  a_done_count: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(st_q.ext_done) && st_q.ext_en |-> st_q.ext_cnt == 9'h100)
    else $error("completion before 256 cycles");
  a_prot_after: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(st_q.rst_prot) |-> $past(st_q.ov) == bbl_pkg::BBL_OV_SPIKE)
    else $error("restart protection without spike blanking");
  a_det_once: assert property (@(posedge aclk) disable iff (!aresetn)
    st_q.det_done |=> st_q.dt == bbl_pkg::BBL_DT_DONE && $stable(st_q.lvl))
    else $error("level changed after detection");
  a_det_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_q.dt == bbl_pkg::BBL_DT_WAIT && prt) |=> st_q.dt == bbl_pkg::BBL_DT_WAIT)
    else $error("detection started under protection");
  a_burst_exit: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_q.burst && fbx) |=> !st_q.burst) else $error("burst not left");
  a_burst_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    !fbl && !st_q.burst |=> st_q.bu_tmr == 32'h0) else $error("burst timer not held");
  c_burst: cover property (@(posedge aclk) disable iff (!aresetn) $rose(st_q.burst));
  c_prot: cover property (@(posedge aclk) disable iff (!aresetn) $rose(st_q.rst_prot));
  c_det: cover property (@(posedge aclk) disable iff (!aresetn) $rose(st_q.det_done));
endmodule

// ==== bbl_far_model.sv ====
// behavioural model of the blanking and feedback capacitors with their comparators
`timescale 1ns/100ps
module bbl_far_model (
  input  wire logic        aclk,
  input  wire logic        charge_switch,
  input  wire logic        discharge_switch,
  input  wire logic        detect_discharge_switch,
  input  wire logic [7:0]  chg_step,
  output logic             blank_hi_cmp,
  output logic             blank_lo_cmp,
  output logic             fb_hi_cmp,
  output logic             fb_lo_cmp,
  output logic [15:0]      blank_hits,
  output logic [15:0]      fb_hits
);
  // ----------------------------------------
  // pin voltages in units of 10 mV
  // ----------------------------------------
  int          vb   = 0;
  int          vf   = 0;
  logic        bh_q = 1'b0;
  logic        fh_q = 1'b0;
  logic [15:0] bh_n = 16'h0;
  logic [15:0] fh_n = 16'h0;
  assign blank_hits = bh_n;
  assign fb_hits    = fh_n;
  // idle blanking pin leaks away, as with a divider resistor on the pin
  always @(posedge aclk) begin
    if (charge_switch) vb <= (vb > 450) ? 500 : vb + 50;
    else if (discharge_switch) vb <= (vb < 100) ? 0 : vb - 100;
    else vb <= (vb < 10) ? 0 : vb - 10;
    if (detect_discharge_switch) vf <= (vf < 100) ? 0 : vf - 100;
    else vf <= (vf + chg_step > 500) ? 500 : vf + chg_step;
    bh_q <= blank_hi_cmp;
    fh_q <= fb_hi_cmp;
    if (blank_hi_cmp && !bh_q) bh_n <= bh_n + 16'h1;
    if (fb_hi_cmp && !fh_q) fh_n <= fh_n + 16'h1;
  end
  assign blank_hi_cmp = (vb >= 450);
  assign blank_lo_cmp = (vb <= 90);
  assign fb_hi_cmp    = (vf >= 450);
  assign fb_lo_cmp    = (vf <= 50);
endmodule

// ==== tb_top.sv ====
// self-checking bench for the blanking and burst level block
`timescale 1ns/100ps
`include "bbl_consts.svh"
module tb_top;
  localparam int BLK = 20;
  localparam int SPK = 30;
  localparam int DET = 2000;
  localparam logic [7:0] STEPS [4] = '{8'h28, 8'h00, 8'h02, 8'h0a};
  logic aclk, aresetn, overload_cmp, blank_hi_cmp, blank_lo_cmp, fb_below_entry_cmp;
  logic fb_above_exit_cmp, fb_hi_cmp, fb_lo_cmp, uvlo_on, protect_active;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rnd, rd;
  logic [3:0]  s_axi_wstrb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0]  s_axi_bresp, s_axi_rresp, burst_entry_threshold, burst_current_limit, rsp, lv;
  logic charge_switch, discharge_switch, detect_discharge_switch, ext_count_done;
  logic restart_protect, burst_mode, burst_hyst_small;
  logic [7:0]  chg_step;
  logic [15:0] blank_hits, fb_hits;
  int n_mismatch, checks_done, n, h0;

  bbl_top #(.BLANK_CYC(BLK), .SPIKE_CYC(SPK), .DETECT_CYC(DET), .CNT_W(16)) DUT (
    .aclk, .aresetn, .overload_cmp, .blank_hi_cmp, .blank_lo_cmp, .fb_below_entry_cmp,
    .fb_above_exit_cmp, .fb_hi_cmp, .fb_lo_cmp, .uvlo_on, .protect_active,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .charge_switch, .discharge_switch,
    .detect_discharge_switch, .ext_count_done, .restart_protect, .burst_mode,
    .burst_hyst_small, .burst_entry_threshold, .burst_current_limit);
  bbl_far_model far (.aclk, .charge_switch, .discharge_switch, .detect_discharge_switch,
    .chg_step, .blank_hi_cmp, .blank_lo_cmp, .fb_hi_cmp, .fb_lo_cmp, .blank_hits, .fb_hits);

  always #5 aclk = ~aclk;
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return (s >> 1) ^ (s[0] ? 32'h8020_0003 : 32'h0);
  endfunction
  function automatic logic [1:0] lvl_of(int c);
    return (c < 4) ? 2'h0 : (c < 16) ? 2'h1 : (c < 64) ? 2'h2 : 2'h3;
  endfunction
  task automatic chk_bit(input string nm, input logic e, input logic g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic do_reset();
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask
  // master waits for the answer, never for a fixed count
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge aclk);
    s_axi_awaddr <= {24'h0, a};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (i = 0; i < 100; i++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    chk_bit("write answer", 1'b1, i < 100);
  endtask
  task automatic axi_rd(input logic [7:0] a);
    int i;
    @(posedge aclk);
    s_axi_araddr <= {24'h0, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (i = 0; i < 100; i++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    rsp = s_axi_rresp;
    rd = s_axi_rdata;
    s_axi_rready <= 1'b0;
    chk_bit("read answer", 1'b1, i < 100);
  endtask
  task automatic wait_for(ref logic s, input logic v, input int lim);
    for (n = 0; n < lim && s !== v; n++) @(posedge aclk);
    chk_bit("wait level", v, s);
  endtask
  task automatic quiet(ref logic s, input int k, input string nm);
    logic seen;
    seen = 1'b0;
    repeat (k) begin
      @(posedge aclk);
      seen = seen | s;
    end
    chk_bit(nm, 1'b0, seen);
  endtask
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    {aclk, aresetn, overload_cmp, fb_below_entry_cmp, fb_above_exit_cmp, uvlo_on} = 6'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
    s_axi_wstrb = 4'hf;
    protect_active = 1'b1;
    chg_step = 8'h0;
    rnd = 32'h0001_683d;
    n_mismatch = 0;
    checks_done = 0;
    @(posedge aclk);
    do_reset();
    axi_rd(`BBL_ADDR_CTRL);
    chk_word("ctrl reset", 32'h0, rd);
    axi_wr(`BBL_ADDR_CTRL, `BBL_CTRL_RST);
    chk_word("ctrl wr resp", 32'h0, {30'h0, rsp});
    axi_rd(`BBL_ADDR_CTRL);
    chk_word("ctrl back", 32'h1, rd);
    axi_wr(`BBL_ADDR_STAT, 32'hffff_ffff);
    chk_word("ro wr resp", 32'h2, {30'h0, rsp});
    axi_rd(8'h10);
    chk_word("unmapped", 32'h2, {30'h0, rsp} | rd);
    $display("test registers done");
    for (int k = 0; k < 4; k++) begin
      chg_step <= STEPS[k];
      uvlo_on <= 1'b0;
      protect_active <= 1'b1;
      do_reset();
      uvlo_on <= 1'b1;
      quiet(detect_discharge_switch, 40, "held detect");
      protect_active <= 1'b0;
      h0 = fb_hits;
      repeat (DET + 40) @(posedge aclk);
      lv = lvl_of(int'(fb_hits) - h0);
      chk_word("entry", {30'h0, lv}, {30'h0, burst_entry_threshold});
      chk_word("limit", {30'h0, lv}, {30'h0, burst_current_limit});
      axi_rd(`BBL_ADDR_LVL);
      chk_word("level reg", {30'h0, lv}, rd & 32'h3);
    end
    $display("test detection done");
    uvlo_on <= 1'b0;
    repeat (10) @(posedge aclk);
    uvlo_on <= 1'b1;
    quiet(detect_discharge_switch, 300, "redetect");
    chk_word("kept level", {30'h0, lv}, {30'h0, burst_entry_threshold});
    rnd = lfsr(rnd);
    fb_below_entry_cmp <= 1'b1;
    repeat (1 + rnd[3:0]) @(posedge aclk);
    fb_below_entry_cmp <= 1'b0;
    quiet(burst_mode, 40, "short dip");
    fb_below_entry_cmp <= 1'b1;
    wait_for(burst_mode, 1'b1, 100);
    chk_bit("burst delay", 1'b1, n >= BLK - 1 && n <= BLK + 6);
    chk_bit("small swing", 1'b1, burst_hyst_small);
    fb_above_exit_cmp <= 1'b1;
    wait_for(burst_mode, 1'b0, 8);
    fb_above_exit_cmp <= 1'b0;
    fb_below_entry_cmp <= 1'b0;
    $display("test burst done");
    do_reset();
    overload_cmp <= 1'b1;
    wait_for(restart_protect, 1'b1, 200);
    chk_bit("basic restart", 1'b1, n >= BLK + SPK - 1 && n <= BLK + SPK + 8);
    chk_bit("basic no charge", 1'b0, charge_switch);
    overload_cmp <= 1'b0;
    do_reset();
    axi_wr(`BBL_ADDR_CTRL, `BBL_CTRL_RST);
    overload_cmp <= 1'b1;
    wait_for(charge_switch, 1'b1, 200);
    chk_bit("ext start", 1'b1, n >= BLK - 1 && n <= BLK + 6);
    chk_bit("ext blocked", 1'b0, restart_protect);
    rnd = lfsr(rnd);
    repeat (20 + rnd[7:0]) @(posedge aclk);
    overload_cmp <= 1'b0;
    repeat (8) @(posedge aclk);
    chk_bit("charge idle", 1'b0, charge_switch);
    chk_bit("discharge idle", 1'b0, discharge_switch);
    axi_rd(`BBL_ADDR_CNT);
    chk_word("ext count clr", 32'h0, {23'h0, rd[24:16]});
    overload_cmp <= 1'b1;
    wait_for(charge_switch, 1'b1, 200);
    h0 = blank_hits;
    wait_for(ext_count_done, 1'b1, 20000);
    chk_word("ext cycles", 32'd256, int'(blank_hits) - h0);
    wait_for(restart_protect, 1'b1, 100);
    chk_bit("spike time", 1'b1, n >= SPK - 1 && n <= SPK + 6);
    $display("test overload done");
    give_verdict();
  end
  initial begin
    repeat (60000) @(posedge aclk);
    n_mismatch++;
    $display("Error watchdog expected end seen timeout");
    give_verdict();
  end
endmodule
